// ### bdfs_map.vh
// Constants for the boot display flash sequencer: opcodes, signature, attribute fields, timing.
// Included by the sequencer and its serial flash reader; definitions only.
`ifndef BDFS_MAP_VH
`define BDFS_MAP_VH
`define BDFS_OP_EXIT0      8'h00
`define BDFS_OP_EXIT1      8'hff
`define BDFS_OP_NOP        8'haa
`define BDFS_OP_WIDE_ON    8'hb7
`define BDFS_OP_WIDE_OFF   8'he9
`define BDFS_OP_POLL_STAT  8'h10
`define BDFS_OP_CMD_WR     8'h11
`define BDFS_OP_POLL_DATA  8'h12
`define BDFS_OP_DATA_WR    8'h13
`define BDFS_OP_LOOP_LOAD  8'h20
`define BDFS_OP_SET_FETCH_ATTRIBUTES       8'h30
`define BDFS_OP_JUMP       8'h80
`define BDFS_OP_DECREMENT_BRANCH_NONZERO       8'h81
`define BDFS_SIG           64'h6172776377627867
`define BDFS_SIG_BYTES     4'h8
`define BDFS_START_ADDR    32'h00000008
`define BDFS_DECREMENT_BRANCH_NONZERO_SKIP     32'h00000005
`define BDFS_RD_PLAIN      8'h03
`define BDFS_RD_FAST       8'h0b
`define BDFS_SET_FETCH_ATTRIBUTES_RESET    8'h30
`define BDFS_SET_FETCH_ATTRIBUTES_DIV      3:0
`define BDFS_SET_FETCH_ATTRIBUTES_MODE3    4
`define BDFS_SET_FETCH_ATTRIBUTES_CSH8     5
`define BDFS_SET_FETCH_ATTRIBUTES_DUMMY    7:6
`define BDFS_CSH_SHORT     4'h4
`define BDFS_CSH_LONG      4'h8
`define BDFS_ADDR_BITS     28
`endif

// ### bdfs_flash_reader.v
// Serial flash byte reader: issues a read command and address, then streams bytes.
// Assumes one core clock; the flash is a plain single-data-line SPI memory.
`timescale 1ns/1ps
`include "bdfs_map.vh"
module bdfs_flash_reader (
  // Clock and reset
  input  wire        core_clk,
  input  wire        reset_n,
  // Stream control
  input  wire        start,
  input  wire        stop,
  input  wire        next,
  input  wire [31:0] addr,
  input  wire        wide,
  input  wire [7:0]  set_fetch_attributes,
  output reg         byte_vld_q,
  output reg  [7:0]  byte_q,
  output reg         busy_q,
  // Flash pins
  output reg         sclk_q,
  output reg         cs_q,
  output reg         mosi_q,
  input  wire        miso
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_CMD  = 4'b0010;
  localparam ST_DATA = 4'b0100;
  localparam ST_DESL = 4'b1000;

  reg [3:0]  st_q;
  reg [3:0]  div_q;
  reg        half_q;
  reg [71:0] sh_q;
  reg [6:0]  bits_q;
  reg [2:0]  bcnt_q;
  reg [7:0]  rx_q;
  reg        hold_q;
  reg [3:0]  csh_q;

  wire        mode3   = set_fetch_attributes[`BDFS_SET_FETCH_ATTRIBUTES_MODE3];
  wire [6:0]  dummy   = {2'h0, set_fetch_attributes[`BDFS_SET_FETCH_ATTRIBUTES_DUMMY], 3'h0};
  wire [7:0]  rd_cmd  = (set_fetch_attributes[`BDFS_SET_FETCH_ATTRIBUTES_DUMMY] == 2'h0) ? `BDFS_RD_PLAIN : `BDFS_RD_FAST;
  wire [6:0]  hdr_len = 7'h8 + (wide ? 7'h20 : 7'h18) + dummy;
  wire        tick    = (div_q == set_fetch_attributes[`BDFS_SET_FETCH_ATTRIBUTES_DIV]);
  wire [3:0]  csh_min = set_fetch_attributes[`BDFS_SET_FETCH_ATTRIBUTES_CSH8] ? `BDFS_CSH_LONG : `BDFS_CSH_SHORT;

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= ST_IDLE; div_q <= 4'h0; half_q <= 1'b0; sh_q <= 72'h0;
      bits_q <= 7'h0; bcnt_q <= 3'h0; rx_q <= 8'h0; hold_q <= 1'b0;
      csh_q <= 4'h0; byte_vld_q <= 1'b0; byte_q <= 8'h0; busy_q <= 1'b0;
      sclk_q <= 1'b1; cs_q <= 1'b1; mosi_q <= 1'b0;
    end else begin
      byte_vld_q <= 1'b0;
      div_q <= tick ? 4'h0 : div_q + 4'h1;
      if (next)
        hold_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          sclk_q <= mode3;
          busy_q <= 1'b0;
          if (start) begin
            st_q <= ST_CMD; cs_q <= 1'b0; busy_q <= 1'b1; half_q <= 1'b0;
            div_q <= 4'h0; bits_q <= hdr_len; hold_q <= 1'b0;
            sh_q <= wide ? {rd_cmd, addr, 32'h0} : {rd_cmd, addr[23:0], 40'h0};
            mosi_q <= rd_cmd[7];
          end
        end
        ST_CMD, ST_DATA: begin
          if (stop) begin
            st_q <= ST_DESL; cs_q <= 1'b1; sclk_q <= mode3; csh_q <= 4'h1;
          end else if (tick && !(hold_q && st_q == ST_DATA && !sclk_q)) begin
            // Pause with the clock low so no rising edge is given before the byte is taken
            sclk_q <= ~sclk_q;
            if (!sclk_q) begin
              // Rising edge: the flash takes one header bit
              half_q <= 1'b1;
              if (st_q == ST_CMD) begin
                bits_q <= bits_q - 7'h1;
                if (bits_q == 7'h1) begin
                  st_q <= ST_DATA;
                  bcnt_q <= 3'h0;
                  half_q <= 1'b0;
                end
              end
            end else if (half_q) begin
              // Falling edge: the first one in mode 3 launches nothing; the pins run a clock
              // behind, so the bit returned after the previous pin fall is still valid here
              if (st_q == ST_CMD) begin
                sh_q <= {sh_q[70:0], 1'b0};
                mosi_q <= sh_q[70];
              end else begin
                half_q <= 1'b0;
                rx_q <= {rx_q[6:0], miso};
                bcnt_q <= bcnt_q + 3'h1;
                if (bcnt_q == 3'h7) begin
                  byte_vld_q <= 1'b1;
                  byte_q <= {rx_q[6:0], miso};
                  hold_q <= 1'b1;
                end
              end
            end
          end
        end
        ST_DESL: begin
          sclk_q <= mode3;
          csh_q <= csh_q + 4'h1;
          if (csh_q >= csh_min)
            st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule

// ### bdfs_sequencer.v
// Boot display flash sequencer: signature probe, byte-coded program execution, host hand-over.
// Assumes synchronous inputs, one core clock, and a register target port for display setup.
//
// Summary of operation
// - Run only when PWM pin strapped high
// - Check eight-byte signature, then fetch from 0008h
// - Execute until exit or undefined opcode
// - 00h, FFh, undefined opcodes exit
// - AAh does nothing, fetch continues
// - 24-bit address default; B7h selects 32-bit
// - E9h restores 24-bit addressing
// - 20h loads the repeat counter
// - 30h bits 3:0 set clock divisor
// - Attribute bit 4 picks mode 0/3
// - Attribute bit 5 picks 4/8 clock deselect
// - Bits 7:6 dummies; read 03h or 0Bh
// - 10h repeats status read until match
// - 11h loads its parameter as register address
// - 12h repeats data read until match
// - 13h writes its parameter as data
// - 80h jumps to 28-bit address
// - 81h decrements and jumps unless counter zero
// - Probe both flash selects for signature
`timescale 1ns/1ps
`include "bdfs_map.vh"
module bdfs_sequencer (
  // Clock and reset
  input  wire       core_clk,
  input  wire       reset_n,
  // Strap
  input  wire       pwm0_strap,
  // Serial flash pins
  output reg        flash_sclk,
  output reg  [1:0] flash_chip_selects,
  output reg        flash_mosi,
  input  wire       flash_miso,
  // Internal register target
  output reg        reg_wr_q,
  output reg        reg_rd_q,
  output reg  [7:0] reg_addr_q,
  output reg  [7:0] reg_wdata_q,
  input  wire [7:0] reg_rdata,
  input  wire       reg_rvalid,
  input  wire [7:0] status_rdata,
  // Status
  output reg        busy_q,
  output reg        host_ctrl_q,
  output reg        sig_found_q,
  output reg        wide_addr_q,
  output reg  [7:0] loop_count_q
);
  localparam ST_STRAP = 9'b000000001;
  localparam ST_PROBE = 9'b000000010;
  localparam ST_PWAIT = 9'b000000100;
  localparam ST_FETCH = 9'b000001000;
  localparam ST_PARAM = 9'b000010000;
  localparam ST_EXEC  = 9'b000100000;
  localparam ST_POLL  = 9'b001000000;
  localparam ST_RESTA = 9'b010000000;
  localparam ST_HOST  = 9'b100000000;

  reg [8:0]  st_q;
  reg        cs_sel_q;
  reg [3:0]  nbyte_q;
  reg [63:0] sig_q;
  reg [31:0] pc_q;
  reg [31:0] op_addr_q;
  reg [7:0]  op_q;
  reg [31:0] par_q;
  reg [2:0]  need_q;
  reg [7:0]  set_fetch_attributes_q;
  reg        rd_start_q;
  reg        rd_stop_q;
  reg        rd_next_q;
  reg        poll_status_q;
  reg        poll_wait_q;

  wire       rd_vld;
  wire [7:0] rd_byte;
  wire       rd_busy;
  wire       rd_sclk;
  wire       rd_cs;
  wire       rd_mosi;

  bdfs_flash_reader u_reader (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .start      (rd_start_q),
    .stop       (rd_stop_q),
    .next       (rd_next_q),
    .addr       (pc_q),
    .wide       (wide_addr_q),
    .set_fetch_attributes       (set_fetch_attributes_q),
    .byte_vld_q (rd_vld),
    .byte_q     (rd_byte),
    .busy_q     (rd_busy),
    .sclk_q     (rd_sclk),
    .cs_q       (rd_cs),
    .mosi_q     (rd_mosi),
    .miso       (flash_miso)
  );

  // Parameter bytes that follow each opcode; zero covers exits and undefined codes
  function [2:0] op_len;
    input [7:0] op;
    begin
      case (op)
        `BDFS_OP_POLL_STAT, `BDFS_OP_CMD_WR, `BDFS_OP_POLL_DATA,
        `BDFS_OP_DATA_WR, `BDFS_OP_LOOP_LOAD, `BDFS_OP_SET_FETCH_ATTRIBUTES: op_len = 3'h1;
        `BDFS_OP_JUMP, `BDFS_OP_DECREMENT_BRANCH_NONZERO: op_len = 3'h4;
        default: op_len = 3'h0;
      endcase
    end
  endfunction

  wire [31:0] jump_addr = {4'h0, par_q[`BDFS_ADDR_BITS-1:0]};
  wire        rd_idle   = !rd_busy && !rd_start_q;

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flash_sclk <= 1'b1;
      flash_chip_selects <= 2'h3;
      flash_mosi <= 1'b0;
    end else begin
      flash_sclk <= rd_sclk;
      flash_mosi <= rd_mosi;
      flash_chip_selects <= cs_sel_q ? {rd_cs, 1'b1} : {1'b1, rd_cs};
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= ST_STRAP;
      cs_sel_q <= 1'b0;
      nbyte_q <= 4'h0;
      sig_q <= 64'h0;
      pc_q <= 32'h0;
      op_addr_q <= 32'h0;
      op_q <= 8'h0;
      par_q <= 32'h0;
      need_q <= 3'h0;
      set_fetch_attributes_q <= `BDFS_SET_FETCH_ATTRIBUTES_RESET;
      rd_start_q <= 1'b0;
      rd_stop_q <= 1'b0;
      rd_next_q <= 1'b0;
      poll_status_q <= 1'b0;
      poll_wait_q <= 1'b0;
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      reg_addr_q <= 8'h0;
      reg_wdata_q <= 8'h0;
      busy_q <= 1'b0;
      host_ctrl_q <= 1'b0;
      sig_found_q <= 1'b0;
      wide_addr_q <= 1'b0;
      loop_count_q <= 8'h0;
    end else begin
      rd_start_q <= 1'b0;
      rd_stop_q <= 1'b0;
      rd_next_q <= 1'b0;
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      case (st_q)
        ST_STRAP: begin
          // Strap is sampled one clock after reset release
          if (pwm0_strap) begin
            st_q <= ST_PROBE; busy_q <= 1'b1; pc_q <= 32'h0;
            rd_start_q <= 1'b1; nbyte_q <= 4'h0;
          end else begin
            st_q <= ST_HOST; host_ctrl_q <= 1'b1;
          end
        end
        ST_PROBE: if (rd_vld) begin
          sig_q <= {sig_q[55:0], rd_byte};
          nbyte_q <= nbyte_q + 4'h1;
          if (nbyte_q == `BDFS_SIG_BYTES - 4'h1) begin
            rd_stop_q <= 1'b1;
            st_q <= ST_PWAIT;
          end else
            rd_next_q <= 1'b1;
        end
        ST_PWAIT: if (rd_idle) begin
          if (sig_q == `BDFS_SIG) begin
            sig_found_q <= 1'b1; pc_q <= `BDFS_START_ADDR;
            rd_start_q <= 1'b1; st_q <= ST_FETCH;
          end else if (!cs_sel_q) begin
            cs_sel_q <= 1'b1; pc_q <= 32'h0; nbyte_q <= 4'h0;
            rd_start_q <= 1'b1; st_q <= ST_PROBE;
          end else begin
            st_q <= ST_HOST; host_ctrl_q <= 1'b1; busy_q <= 1'b0;
          end
        end
        ST_FETCH: if (rd_vld) begin
          op_q <= rd_byte; op_addr_q <= pc_q;
          pc_q <= pc_q + 32'h1;
          need_q <= op_len(rd_byte);
          par_q <= 32'h0;
          // The byte after a complete instruction is asked for only once it can be taken,
          // since the reader hands each byte over as a single pulse
          rd_next_q <= (op_len(rd_byte) != 3'h0);
          st_q <= (op_len(rd_byte) == 3'h0) ? ST_EXEC : ST_PARAM;
        end
        ST_PARAM: if (rd_vld) begin
          par_q <= {par_q[23:0], rd_byte};
          pc_q <= pc_q + 32'h1;
          need_q <= need_q - 3'h1;
          rd_next_q <= (need_q != 3'h1);
          if (need_q == 3'h1)
            st_q <= ST_EXEC;
        end
        ST_EXEC: begin
          st_q <= ST_FETCH;
          rd_next_q <= 1'b1;
          case (op_q)
            `BDFS_OP_NOP: ;
            `BDFS_OP_WIDE_ON: begin
              wide_addr_q <= 1'b1; rd_stop_q <= 1'b1; st_q <= ST_RESTA;
            end
            `BDFS_OP_WIDE_OFF: begin
              wide_addr_q <= 1'b0; rd_stop_q <= 1'b1; st_q <= ST_RESTA;
            end
            `BDFS_OP_LOOP_LOAD: loop_count_q <= par_q[7:0];
            `BDFS_OP_SET_FETCH_ATTRIBUTES: begin
              // New mode and deselect length apply from the deselect ending this access; divisor and dummies from the next access
              set_fetch_attributes_q <= par_q[7:0];
              rd_stop_q <= 1'b1; st_q <= ST_RESTA;
            end
            `BDFS_OP_CMD_WR: reg_addr_q <= par_q[7:0];
            `BDFS_OP_DATA_WR: begin
              reg_wdata_q <= par_q[7:0]; reg_wr_q <= 1'b1;
            end
            `BDFS_OP_POLL_STAT, `BDFS_OP_POLL_DATA: begin
              poll_status_q <= (op_q == `BDFS_OP_POLL_STAT);
              poll_wait_q <= 1'b0; st_q <= ST_POLL;
              rd_next_q <= 1'b0;
            end
            `BDFS_OP_JUMP: begin
              pc_q <= jump_addr; rd_stop_q <= 1'b1; st_q <= ST_RESTA;
            end
            `BDFS_OP_DECREMENT_BRANCH_NONZERO: begin
              if (loop_count_q != 8'h0) begin
                loop_count_q <= loop_count_q - 8'h1;
                pc_q <= jump_addr; rd_stop_q <= 1'b1; st_q <= ST_RESTA;
              end else
                pc_q <= op_addr_q + `BDFS_DECREMENT_BRANCH_NONZERO_SKIP;
            end
            default: begin
              rd_stop_q <= 1'b1;
              st_q <= ST_HOST; host_ctrl_q <= 1'b1; busy_q <= 1'b0;
            end
          endcase
        end
        ST_POLL: begin
          // Status is read directly; data goes through the register port handshake
          if (poll_status_q) begin
            if (status_rdata == par_q[7:0]) begin
              st_q <= ST_FETCH;
              rd_next_q <= 1'b1;
            end
          end else if (!poll_wait_q) begin
            reg_rd_q <= 1'b1; poll_wait_q <= 1'b1;
          end else if (reg_rvalid) begin
            poll_wait_q <= 1'b0;
            if (reg_rdata == par_q[7:0]) begin
              st_q <= ST_FETCH;
              rd_next_q <= 1'b1;
            end
          end
        end
        ST_RESTA: if (rd_idle) begin
          rd_start_q <= 1'b1; st_q <= ST_FETCH;
        end
        ST_HOST: busy_q <= 1'b0;
        default: st_q <= ST_HOST;
      endcase
    end
  end
endmodule

// ### bdfs_flash_model.sv
// Behavioural serial flash: read command, 24/32-bit address, then bytes out MSB first.
// Assumes mode 3 timing and no dummy bits; the bench fills mem directly.
`timescale 1ns/1ps
module bdfs_flash_model (
  // Flash pins
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic mosi,
  output logic      miso,
  // Address width in use
  input  wire logic wide
);
  logic [7:0]  mem [0:255];
  logic [31:0] addr;
  int          cnt;
  int          idx;
  wire  [5:0]  hdr = wide ? 6'd40 : 6'd32;
  initial miso = 1'b0;
  always @(negedge cs_n) cnt = 0;
  always @(posedge sclk) if (!cs_n) begin
    if (cnt >= 8 && cnt < hdr) addr = {addr[30:0], mosi};
    cnt = cnt + 1;
  end
  // Outside the data phase the line toggles, so stale bits never look valid
  always @(negedge sclk or posedge cs_n) begin
    idx = cnt - hdr;
    if (!cs_n && cnt >= hdr) miso <= mem[8'(addr + idx / 8)][7 - idx % 8];
    else miso <= ~miso;
  end
endmodule

// ### bdfs_sequencer_sva.sv
// Port checks for the boot display flash sequencer.
// Assumes default fetch attributes (mode 3, 8-clock deselect) throughout.
`timescale 1ns/1ps
module bdfs_sequencer_sva (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       reset_n,
  // Watched ports
  input wire logic       pwm0_strap,
  input wire logic       flash_sclk,
  input wire logic [1:0] flash_chip_selects,
  input wire logic       reg_wr_q,
  input wire logic       reg_rd_q,
  input wire logic       busy_q,
  input wire logic       host_ctrl_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  strap_off_a: assert property (!pwm0_strap && !busy_q && !host_ctrl_q |-> ##[1:3] host_ctrl_q)
    else $error("strap low did not hand over");
  host_sticky_a: assert property (host_ctrl_q |=> host_ctrl_q)
    else $error("host control dropped");
  host_quiet_a: assert property (host_ctrl_q |-> !busy_q && !reg_wr_q)
    else $error("activity after hand over");
  one_select_a: assert property (flash_chip_selects != 2'b00)
    else $error("both flashes selected");
  wr_pulse_a: assert property (reg_wr_q |=> !reg_wr_q)
    else $error("register write longer than one cycle");
  rd_pulse_a: assert property (reg_rd_q |=> !reg_rd_q)
    else $error("register read longer than one cycle");
  select_gap_a: assert property ($rose(flash_chip_selects[0]) |-> flash_chip_selects[0] [*8])
    else $error("deselect time too short");
  sclk_idle_a: assert property (flash_chip_selects == 2'b11 && $past(flash_chip_selects) == 2'b11
    |-> flash_sclk)
    else $error("serial clock not idle high");
endmodule

// ### bdfs_sequencer_bench.sv
// Self-checking bench: two flash models, register port responder, four scenarios.
// Assumes a 100 MHz core clock and default fetch attributes.
`timescale 1ns/1ps
module bdfs_sequencer_bench;
  logic       core_clk = 0, reset_n = 0, pwm0_strap = 0, reg_rvalid = 0;
  logic [7:0] reg_rdata = 0, status_rdata = 0, reg_addr_q, reg_wdata_q, loop_count_q, waddr, wdata;
  logic [1:0] flash_chip_selects;
  logic       flash_sclk, flash_mosi, miso0, miso1, reg_wr_q, reg_rd_q;
  logic       busy_q, host_ctrl_q, sig_found_q, wide_addr_q, saw_wide, saw_cs1;
  int         nwr, nrd, bad_count, checks_done;
  logic [7:0] sig [$] = '{8'h61, 8'h72, 8'h77, 8'h63, 8'h77, 8'h62, 8'h78, 8'h67};
  wire        flash_miso = flash_chip_selects[0] ? miso1 : miso0;
  always #5 core_clk = ~core_clk;
  bdfs_sequencer dut (.core_clk(core_clk), .reset_n(reset_n), .pwm0_strap(pwm0_strap),
    .flash_sclk(flash_sclk), .flash_chip_selects(flash_chip_selects), .flash_mosi(flash_mosi),
    .flash_miso(flash_miso), .reg_wr_q(reg_wr_q), .reg_rd_q(reg_rd_q), .reg_addr_q(reg_addr_q),
    .reg_wdata_q(reg_wdata_q), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .status_rdata(status_rdata), .busy_q(busy_q), .host_ctrl_q(host_ctrl_q),
    .sig_found_q(sig_found_q), .wide_addr_q(wide_addr_q), .loop_count_q(loop_count_q));
  bdfs_flash_model fl0 (.sclk(flash_sclk), .cs_n(flash_chip_selects[0]), .mosi(flash_mosi),
    .miso(miso0), .wide(wide_addr_q));
  bdfs_flash_model fl1 (.sclk(flash_sclk), .cs_n(flash_chip_selects[1]), .mosi(flash_mosi),
    .miso(miso1), .wide(wide_addr_q));
  always @(posedge core_clk or negedge reset_n)
    if (!reset_n) begin
      nwr <= 0; nrd <= 0; saw_wide <= 0; saw_cs1 <= 0;
    end else begin
      if (reg_wr_q) begin
        nwr <= nwr + 1; waddr <= reg_addr_q; wdata <= reg_wdata_q;
      end
      if (reg_rd_q) nrd <= nrd + 1;
      if (wide_addr_q) saw_wide <= 1;
      if (!flash_chip_selects[1]) saw_cs1 <= 1;
    end
  // First data poll answer is wrong on purpose so the read must repeat
  always @(negedge core_clk) begin
    reg_rvalid <= reg_rd_q;
    reg_rdata <= nrd < 1 ? 8'h76 : 8'h77;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic boot(input logic strap, input logic [7:0] p0 [$], input logic [7:0] p1 [$]);
    @(negedge core_clk);
    reset_n = 0; pwm0_strap = strap; status_rdata = 8'h00;
    for (int i = 0; i < 256; i++) begin
      fl0.mem[i] = i < p0.size() ? p0[i] : 8'hff;
      fl1.mem[i] = i < p1.size() ? p1[i] : 8'hff;
    end
    repeat (10) @(negedge core_clk);
    reset_n = 1;
  endtask
  task automatic wait_host;
    for (int n = 0; n < 20000 && host_ctrl_q !== 1'b1; n++) @(negedge core_clk);
  endtask
  task automatic t_strap_off;
    boot(0, sig, sig);
    repeat (5) @(negedge core_clk);
    check("host", host_ctrl_q, 1);
    check("busy", busy_q, 0);
    check("selects", flash_chip_selects, 2'b11);
  endtask
  task automatic t_no_sig;
    boot(1, {sig[0:6], 8'h66}, {sig[0:6], 8'h66});
    wait_host;
    check("host", host_ctrl_q, 1);
    check("sig", sig_found_q, 0);
    check("probe1", saw_cs1, 1);
    check("writes", nwr, 0);
  endtask
  task automatic t_program;
    boot(1, {sig, 8'haa, 8'h20, 8'h02, 8'h11, 8'h45, 8'h13, 8'h5a, 8'h81, 8'h00, 8'h00, 8'h00,
      8'h0d, 8'hb7, 8'h80, 8'h00, 8'h00, 8'h00, 8'h20, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
      8'he9, 8'h12, 8'h77, 8'h10, 8'h33, 8'h00}, {sig[0:6], 8'h66});
    for (int n = 0; n < 20000 && nrd < 2; n++) @(negedge core_clk);
    repeat (40) @(negedge core_clk);
    check("poll wait", host_ctrl_q, 0);
    status_rdata = 8'h33;
    wait_host;
    check("host", host_ctrl_q, 1);
    check("sig", sig_found_q, 1);
    check("writes", nwr, 3);
    check("waddr", waddr, 8'h45);
    check("wdata", wdata, 8'h5a);
    check("reads", nrd, 2);
    check("wide seen", saw_wide, 1);
    check("wide off", wide_addr_q, 0);
    check("loop", loop_count_q, 0);
  endtask
  task automatic t_second_flash;
    boot(1, {sig[0:6], 8'h66}, {sig, 8'h20, 8'h09, 8'h55, 8'h11, 8'h01, 8'h13, 8'h02});
    wait_host;
    check("sig", sig_found_q, 1);
    check("loop", loop_count_q, 8'h09);
    check("writes", nwr, 0);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    t_strap_off;
    t_no_sig;
    t_program;
    t_second_flash;
    test_done;
  end
  initial begin
    #800000;
    bad_count++;
    test_done;
  end
endmodule
bind bdfs_sequencer bdfs_sequencer_sva sva (.core_clk(core_clk), .reset_n(reset_n), .pwm0_strap(pwm0_strap),
  .flash_sclk(flash_sclk), .flash_chip_selects(flash_chip_selects), .reg_wr_q(reg_wr_q),
  .reg_rd_q(reg_rd_q), .busy_q(busy_q), .host_ctrl_q(host_ctrl_q));
